// ===== rtl/adcr_pkg.sv
/*
 package for the converter control block: register offsets, field positions, reset values, timing.
 assumes a plain 8-bit register port with read data one cycle after the read strobe.
*/
package adcr_pkg;
    // register offsets (byte index on the local port)
    localparam logic [2:0] OFS_CONV_CTRL = 3'h0;   // converter_control
    localparam logic [2:0] OFS_STAT_CTRL = 3'h1;   // conversion_status_control
    localparam logic [2:0] OFS_RES_HIGH = 3'h2;    // result_high_byte
    localparam logic [2:0] OFS_RES_LOW = 3'h3;     // result_low_byte
    // converter_control fields
    localparam int POS_POWER_ON = 7;
    localparam int POS_JUSTIFY_RIGHT = 6;
    localparam int POS_EIGHT_BIT = 5;
    localparam int POS_SIGNED = 4;
    localparam int POS_PRESCALE = 0;
    // conversion_status_control fields
    localparam int POS_DONE_FLAG = 7;
    localparam int POS_IRQ_ENABLE = 6;
    localparam int POS_CONTINUOUS = 5;
    localparam int POS_CHANNEL = 0;
    // reset values
    localparam logic [7:0] RST_CONV_CTRL = 8'h00;
    localparam logic [7:0] RST_STAT_CTRL = 8'h1f;  // channel lower_reference, idle
    localparam logic [9:0] RST_RESULT = 10'h000;
    // channel codes
    localparam logic [4:0] CH_LAST_INPUT = 5'h07;
    localparam logic [4:0] CH_UPPER_REF = 5'h1e;
    // analog core latency in conversion clock cycles
    localparam int CONV_CYCLES = 14;
    // core clock period, for reference
    localparam int CORE_CLK_NS = 5;

    // register port request
    typedef struct packed {
        logic [2:0] addr;   // register offset
        logic [7:0] wdata;  // write data
        logic wr;           // write strobe
        logic rd;           // read strobe
    } adcr_req_s;

    // analog sample request towards the core
    typedef struct packed {
        logic [2:0] input_sel;   // multiplexer input
        logic use_upper_ref;     // convert upper_reference
        logic use_lower_ref;     // convert lower_reference
    } adcr_sel_s;
endpackage

// ===== rtl/adcr_prescaler.sv
/*
 conversion clock prescaler: emits one tick every (prescale_select+1)*2 core clocks.
 assumes prescale_select is stable while running; restart reloads the count.
*/
`timescale 1ns/1ps
`default_nettype none
module adcr_prescaler #(
    parameter int SEL_W = 4  // prescale select width
) (
    input wire logic core_clk,          // bus clock
    input wire logic sys_rst,           // synchronous reset, high
    input wire logic restart,           // reload count, no tick
    input wire logic run,               // count while high
    input wire logic [SEL_W-1:0] sel,   // prescale select
    output logic tick                   // one-cycle conversion clock edge
);
    import adcr_pkg::*;
    logic [SEL_W:0] cnt_q, cnt_d;  // cycles left until tick
    logic [SEL_W:0] reload;        // divisor minus one
    // divisor = (sel+1)*2, so reload is 2*sel+1
    assign reload = {sel, 1'b1}; // RULE_01
    // next count and tick
    always_comb begin
        cnt_d = cnt_q;
        tick = 1'b0;
        if (restart || !run) begin
            cnt_d = reload;  // hold at full period
        end else if (cnt_q == '0) begin
            tick = 1'b1;     // RULE_01
            cnt_d = reload;
        end else begin
            cnt_d = cnt_q - 1'b1;
        end
    end
    // count register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // adcr_prescaler
`default_nettype wire

// ===== rtl/adcr_top.sv
/*
 converter control and result registers: prescaler, status/control, channel select, result format.
 assumes an analog core that samples the selected input while sample_en is high and presents a
 10-bit code on core_code from a pin domain; code is synchronised before use.
*/
// Implementation choices: the register addresses and strobed register access.
// Function
// RULE_01: conversion clock is bus over (sel+1)*2
// RULE_02: software keeps conversion clock 500k to 2M; divisors 2 to 32 at 200 MHz give only 6.25 to 100 MHz
// RULE_03: status write clears flag, restarts conversion
// RULE_04: done flag bit 7, read-only, sets on finish
// RULE_05: result byte read clears done flag
// RULE_06: enabled interrupt pends while done flag set
// RULE_07: results loaded before flag and interrupt
// RULE_08: system reset clears pending interrupt
// RULE_09: without enable software polls done flag
// RULE_10: continuous mode converts repeatedly, updates results
// RULE_11: single mode converts once per status write
// RULE_12: channel codes 00-07 pick inputs zero-seven
// RULE_13: 08-1d and 1f low ref, 1e high
// RULE_14: left justify: bits 9-2 high, 1-0 low[7:6]
// RULE_15: right justify: bits 9-8 high[1:0], 7-0 low
// RULE_16: eight-bit result in high, low reads zero
// RULE_17: unused ten-bit result bits read zero
// RULE_18: result registers are read-only
// RULE_19: control write aborts, starts nothing
// RULE_20: power-off aborts, enters low power
// RULE_21: bit 5 eight-bit, bit 6 right justify
// RULE_22: signed left justify inverts result msb
// RULE_23: core returns code after fixed cycles
// RULE_24: abort keeps flag and results unchanged
`timescale 1ns/1ps
`default_nettype none
module adcr_top #(
    parameter int CONV_LEN = adcr_pkg::CONV_CYCLES  // conversion clocks per conversion
) (
    input wire logic core_clk,                 // bus clock, 200 MHz
    input wire logic sys_rst,                  // synchronous reset, high
    input wire adcr_pkg::adcr_req_s regReq,    // register port request
    output logic [7:0] regRdata,               // read data, cycle after read strobe
    input wire logic [9:0] coreCode,           // analog core code, asynchronous
    output adcr_pkg::adcr_sel_s coreSel,       // selected analog source
    output logic samplePowerOn,                // analog core powered
    output logic sampleEn,                     // conversion in progress
    output logic doneIrq                       // interrupt request, level
);
    import adcr_pkg::*;

    // conversion states, gray along idle->convert->load
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_LOAD = 2'b11
    } adcr_state_e;

    localparam int CNT_W = $clog2(CONV_LEN + 1);  // conversion clock counter width

    // register state
    logic [7:0] convCtrl_q, convCtrl_d;     // converter_control
    logic doneFlag_q, doneFlag_d;           // conversion_done_flag
    logic irqEnable_q, irqEnable_d;         // done_irq_enable
    logic continuous_q, continuous_d;       // continuous_mode
    logic [4:0] channel_q, channel_d;       // channel_select
    logic [7:0] resHigh_q, resHigh_d;       // result_high_byte
    logic [7:0] resLow_q, resLow_d;         // result_low_byte
    logic [7:0] rdata_q, rdata_d;           // registered read data
    // sequencer state
    adcr_state_e state_q, state_d;          // conversion state
    logic [CNT_W-1:0] cnt_q, cnt_d;         // conversion clocks left
    // synchroniser on the asynchronous core code
    logic [9:0] codeMeta_q;                 // first stage, read only by second
    logic [9:0] codeSync_q;                 // second stage
    // decoded strobes
    logic wrStat, wrCtrl, rdResult;         // register accesses
    logic powerOn;                          // converter_power_on
    logic convTick;                         // conversion clock edge
    logic startConv;                        // start a new conversion
    logic abortConv;                        // abort without restart
    logic finish;                           // conversion finished this cycle
    logic [7:0] fmtHigh, fmtLow;            // formatted result bytes

    // register port decode
    assign wrStat = regReq.wr && (regReq.addr == OFS_STAT_CTRL);
    assign wrCtrl = regReq.wr && (regReq.addr == OFS_CONV_CTRL);
    assign rdResult = regReq.rd && ((regReq.addr == OFS_RES_HIGH) || (regReq.addr == OFS_RES_LOW)); // RULE_05
    assign powerOn = convCtrl_q[POS_POWER_ON];
    assign startConv = wrStat && powerOn; // RULE_03
    assign abortConv = wrCtrl || !powerOn; // RULE_19 RULE_20

    // conversion clock prescaler
    adcr_prescaler #(
        .SEL_W(4)
    ) uPrescaler (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .restart(startConv),
        .run(state_q == ST_CONV),
        .sel(convCtrl_q[POS_PRESCALE +: 4]),
        .tick(convTick)
    );

    // result formatting from resolution, justification and sign
    function automatic logic [15:0] fmtResult(input logic [9:0] code, input logic [7:0] ctrl);
        logic [9:0] val;
        logic [15:0] res;
        val = code;
        res = 16'h0000;
        // sign is honoured only with justify_right clear, in either resolution
        if (ctrl[POS_SIGNED] && !ctrl[POS_JUSTIFY_RIGHT]) begin
            val[9] = ~code[9];  // RULE_22
        end
        if (ctrl[POS_EIGHT_BIT]) begin
            res = {val[9:2], 8'h00};  // RULE_16 RULE_21
        end else if (ctrl[POS_JUSTIFY_RIGHT]) begin
            res = {6'h00, val[9:8], val[7:0]};  // RULE_15 RULE_17 RULE_21
        end else begin
            res = {val[9:2], val[1:0], 6'h00};  // RULE_14 RULE_17
        end
        return res;
    endfunction

    assign {fmtHigh, fmtLow} = fmtResult(codeSync_q, convCtrl_q);

    // conversion sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        finish = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // wait for a status write
            end
            ST_CONV: begin
                if (convTick) begin
                    if (cnt_q == CNT_W'(1)) begin
                        state_d = ST_LOAD;  // RULE_23
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
            end
            ST_LOAD: begin
                finish = 1'b1;  // code is stable in synchroniser
                if (continuous_q) begin
                    state_d = ST_CONV;  // RULE_10
                    cnt_d = CNT_W'(CONV_LEN);
                end else begin
                    state_d = ST_IDLE;  // RULE_11
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (abortConv) begin
            state_d = ST_IDLE;  // RULE_19 RULE_20 RULE_24
            finish = 1'b0;
        end
        if (startConv) begin
            state_d = ST_CONV;  // RULE_03 RULE_11
            cnt_d = CNT_W'(CONV_LEN);
            finish = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // register file next values
    always_comb begin
        convCtrl_d = convCtrl_q;
        irqEnable_d = irqEnable_q;
        continuous_d = continuous_q;
        channel_d = channel_q;
        resHigh_d = resHigh_q;
        resLow_d = resLow_q;
        doneFlag_d = doneFlag_q;
        rdata_d = 8'h00;
        if (wrCtrl) begin
            convCtrl_d = regReq.wdata;
        end
        if (wrStat) begin
            irqEnable_d = regReq.wdata[POS_IRQ_ENABLE];
            continuous_d = regReq.wdata[POS_CONTINUOUS];
            channel_d = regReq.wdata[POS_CHANNEL +: 5];
        end
        // clears first, so a conversion finishing in the same cycle as a result read wins
        if (wrStat || rdResult) begin
            doneFlag_d = 1'b0;  // RULE_03 RULE_05
        end
        if (finish) begin
            resHigh_d = fmtHigh;  // RULE_07 RULE_10
            resLow_d = fmtLow;
            doneFlag_d = 1'b1;  // RULE_04
        end
        // result registers ignore writes
        if (regReq.rd) begin
            case (regReq.addr)
                OFS_CONV_CTRL: rdata_d = convCtrl_q;
                OFS_STAT_CTRL: rdata_d = {doneFlag_q, irqEnable_q, continuous_q, channel_q};  // RULE_04
                OFS_RES_HIGH: rdata_d = resHigh_q;  // RULE_18
                OFS_RES_LOW: rdata_d = resLow_q;  // RULE_18
                default: rdata_d = 8'h00;  // unmapped reads zero
            endcase
        end
    end

    // register file flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            convCtrl_q <= RST_CONV_CTRL;
            doneFlag_q <= RST_STAT_CTRL[POS_DONE_FLAG];  // RULE_08
            irqEnable_q <= RST_STAT_CTRL[POS_IRQ_ENABLE];
            continuous_q <= RST_STAT_CTRL[POS_CONTINUOUS];
            channel_q <= RST_STAT_CTRL[POS_CHANNEL +: 5];
            resHigh_q <= RST_RESULT[9:2];
            resLow_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            convCtrl_q <= convCtrl_d;
            doneFlag_q <= doneFlag_d;
            irqEnable_q <= irqEnable_d;
            continuous_q <= continuous_d;
            channel_q <= channel_d;
            resHigh_q <= resHigh_d;
            resLow_q <= resLow_d;
            rdata_q <= rdata_d;
        end
    end

    // two-stage synchroniser on core code
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            codeMeta_q <= 10'h000;
            codeSync_q <= 10'h000;
        end else begin
            codeMeta_q <= coreCode;
            codeSync_q <= codeMeta_q;
        end
    end

    // channel decode towards the analog multiplexer
    always_comb begin
        coreSel.input_sel = channel_q[2:0];
        coreSel.use_upper_ref = 1'b0;
        coreSel.use_lower_ref = 1'b0;
        if (channel_q == CH_UPPER_REF) begin
            coreSel.use_upper_ref = 1'b1;  // RULE_13
        end else if (channel_q > CH_LAST_INPUT) begin
            coreSel.use_lower_ref = 1'b1;  // RULE_13
        end
        if (coreSel.use_upper_ref || coreSel.use_lower_ref) begin
            coreSel.input_sel = 3'h0;
        end  // RULE_12
    end

    assign regRdata = rdata_q;
    assign samplePowerOn = powerOn;  // RULE_20
    assign sampleEn = (state_q == ST_CONV);
    assign doneIrq = doneFlag_q && irqEnable_q;  // RULE_06
endmodule // adcr_top
`default_nettype wire

// ===== tb/adcr_core_model.sv
/*
 behavioural analog core: returns the code of the selected source while sampleEn and samplePowerOn are high, its complement otherwise.
 assumes the bench supplies one 10-bit value per analog input.
*/
`timescale 1ns/1ps
`default_nettype none
module adcr_core_model (
    input wire adcr_pkg::adcr_sel_s coreSel, // selected source
    input wire logic samplePowerOn,          // core powered
    input wire logic sampleEn,               // conversion running
    input wire logic [7:0][9:0] inputVals,   // analog input levels
    output logic [9:0] coreCode              // code towards the block
);
    import adcr_pkg::*;
    logic [9:0] srcCode; // code of the chosen source
    // pick the source the multiplexer points at
    always_comb begin
        if (coreSel.use_upper_ref) begin
            srcCode = 10'h3ff;
        end else if (coreSel.use_lower_ref) begin
            srcCode = 10'h000;
        end else begin
            srcCode = inputVals[coreSel.input_sel];
        end
    end
    // outside a conversion the node drifts, so a stale code is never offered
    assign coreCode = (sampleEn && samplePowerOn) ? srcCode : ~srcCode;
endmodule // adcr_core_model
`default_nettype wire

// ===== tb/adcr_top_props.sv
/*
 concurrent checks on the converter block ports.
 assumes register writes are the only way to change control fields.
*/
`timescale 1ns/1ps
`default_nettype none
module adcr_top_props #(
    parameter int CONV_LEN = 14 // conversion clocks per conversion
) (
    input wire logic core_clk,               // bus clock
    input wire logic sys_rst,                // synchronous reset
    input wire adcr_pkg::adcr_req_s regReq,  // register request
    input wire logic [7:0] regRdata,         // read data
    input wire logic [9:0] coreCode,         // analog code
    input wire adcr_pkg::adcr_sel_s coreSel, // selected source
    input wire logic samplePowerOn,          // core powered
    input wire logic sampleEn,               // converting
    input wire logic doneIrq                 // interrupt request
);
    import adcr_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic statWr, ctrlWr; // write strobes per register
    logic irqEnQ, irqEnD, contQ, contD; // tracked status bits
    logic [4:0] chanQ, chanD; // tracked channel
    logic [3:0] prsQ, prsD; // tracked prescale
    logic [9:0] cntQ, cntD; // cycles of the running conversion
    int spanLo, spanHi; // allowed conversion length
    assign statWr = regReq.wr && regReq.addr == OFS_STAT_CTRL;
    assign ctrlWr = regReq.wr && regReq.addr == OFS_CONV_CTRL;
    // shadow of the software-visible fields
    always_comb begin
        irqEnD = statWr ? regReq.wdata[6] : irqEnQ;
        contD = statWr ? regReq.wdata[5] : contQ;
        chanD = statWr ? regReq.wdata[4:0] : chanQ;
        prsD = ctrlWr ? regReq.wdata[3:0] : prsQ;
        cntD = (statWr || !sampleEn) ? 10'h000 : cntQ + 10'h001;
        spanLo = CONV_LEN * (int'(prsQ) + 1) * 2 - 1;
        spanHi = spanLo + 3;
    end
    // register the shadow
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqEnQ <= 1'b0;
            contQ <= 1'b0;
            chanQ <= RST_STAT_CTRL[4:0];
            prsQ <= 4'h0;
            cntQ <= 10'h000;
        end else begin
            irqEnQ <= irqEnD;
            contQ <= contD;
            chanQ <= chanD;
            prsQ <= prsD;
            cntQ <= cntD;
        end
    end
    sequence s_stat_wr;
        statWr && samplePowerOn;
    endsequence
    sequence s_conv_end;
        $fell(sampleEn) && !$past(ctrlWr);
    endsequence
    a_reset_clear: assert property ($fell(sys_rst) |-> !doneIrq && !sampleEn && regRdata == 8'h00)
        else $error("state not clear after reset");
    a_wr_clears_irq: assert property (statWr |=> !doneIrq)
        else $error("status write left interrupt pending");
    a_rd_clears_irq: assert property (regReq.rd && regReq.addr[2:1] == 2'b01 && !sampleEn && !$fell(sampleEn)
        |=> !doneIrq)
        else $error("result read left interrupt pending");
    a_conv_start: assert property (s_stat_wr |=> sampleEn)
        else $error("status write did not start conversion");
    a_ctrl_abort: assert property (ctrlWr |=> !sampleEn)
        else $error("control write did not abort");
    a_power_gate: assert property (!samplePowerOn |-> !sampleEn)
        else $error("converting while powered down");
    a_conv_span: assert property (s_conv_end |-> cntQ >= spanLo && cntQ <= spanHi)
        else $error("conversion length off");
    a_done_irq: assert property (s_conv_end ##0 (irqEnQ && !statWr && !ctrlWr) |=> doneIrq)
        else $error("no interrupt at completion");
    a_irq_gate: assert property (doneIrq |-> irqEnQ)
        else $error("interrupt without enable");
    a_single_stop: assert property (s_conv_end ##0 (!contQ && !statWr) ##1 !statWr [*2]
        |-> !sampleEn && !$past(sampleEn))
        else $error("single conversion restarted");
    a_chan_map: assert property (coreSel.use_upper_ref == (chanQ == CH_UPPER_REF)
        && coreSel.use_lower_ref == (chanQ > CH_LAST_INPUT && chanQ != CH_UPPER_REF)
        && (chanQ > CH_LAST_INPUT || coreSel.input_sel == chanQ[2:0]))
        else $error("channel routed wrongly");
    a_status_read: assert property (regReq.rd && regReq.addr == OFS_STAT_CTRL
        |=> regRdata[6:0] == {irqEnQ, contQ, chanQ})
        else $error("status fields read back wrongly");
endmodule // adcr_top_props
bind adcr_top adcr_top_props #(.CONV_LEN(CONV_LEN)) u_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .regReq(regReq), .regRdata(regRdata), .coreCode(coreCode), .coreSel(coreSel),
    .samplePowerOn(samplePowerOn), .sampleEn(sampleEn), .doneIrq(doneIrq));
`default_nettype wire

// ===== tb/adcr_top_tb.sv
/*
 self-checking bench for the converter block with a behavioural core.
 assumes a short conversion length so the run stays brief.
*/
`timescale 1ns/1ps
`default_nettype none
module adcr_top_tb;
    import adcr_pkg::*;
    localparam int N = 3; // shortened conversion length
    logic core_clk = 1'b0; // bus clock
    logic sys_rst = 1'b1; // reset
    adcr_req_s regReq = '0; // register request
    logic [7:0] regRdata; // read data
    logic [9:0] coreCode; // core code
    adcr_sel_s coreSel; // selected source
    logic samplePowerOn, sampleEn, doneIrq; // status outputs
    logic [7:0][9:0] inputVals = '0; // analog levels
    logic [7:0] expQ[$]; // expected read data
    string nameQ[$]; // names of expected reads
    logic rdWas = 1'b0; // read strobe seen last cycle
    int n_fail = 0;
    int check_count = 0;
    int lenA, lenB; // measured conversion lengths
    logic [15:0] f; // expected result bytes
    logic [4:0] chList [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h1d, 5'h1e, 5'h1f};
    logic [7:0] modes [8] = '{8'h80, 8'h90, 8'hc0, 8'hd0, 8'ha0, 8'hb0, 8'he0, 8'hf0};
    adcr_top #(.CONV_LEN(N)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
        .coreCode(coreCode), .coreSel(coreSel), .samplePowerOn(samplePowerOn), .sampleEn(sampleEn), .doneIrq(doneIrq));
    adcr_core_model core (.coreSel(coreSel), .samplePowerOn(samplePowerOn), .sampleEn(sampleEn),
        .inputVals(inputVals), .coreCode(coreCode));
    // clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        regReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
        expQ.push_back(e);
        nameQ.push_back(nm);
        @(posedge core_clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        regReq.rd <= 1'b0;
    endtask
    task automatic wait_idle(output int len);
        len = 0;
        @(negedge core_clk);
        while (sampleEn === 1'b1 && len < 5000) begin
            @(negedge core_clk);
            len++;
        end
        if (len >= 5000) n_fail++;
        // flag and interrupt register on the edge that ends the load cycle
        @(negedge core_clk);
    endtask
    function automatic logic [15:0] fmt(input logic [7:0] c, input logic [9:0] v);
        logic [9:0] s;
        s = {v[9] ^ (c[4] & ~c[6]), v[8:0]};
        if (c[5]) return {s[9:2], 8'h00};
        if (c[6]) return {6'h00, v};
        return {s, 6'h00};
    endfunction
    task automatic conv(input logic [7:0] st, input logic [9:0] v, input logic [7:0] c);
        f = fmt(c, v);
        wr(OFS_STAT_CTRL, st);
        wait_idle(lenA);
        rd(OFS_STAT_CTRL, {1'b1, st[6:0]}, "statusDone");
        rd(OFS_RES_HIGH, f[15:8], "resHigh");
        rd(OFS_RES_LOW, f[7:0], "resLow");
        rd(OFS_STAT_CTRL, {1'b0, st[6:0]}, "statusClear");
    endtask
    // read data checker: one note per read strobe
    always @(negedge core_clk) begin
        if (rdWas && expQ.size() > 0) chk(nameQ.pop_front(), expQ.pop_front(), regRdata);
        rdWas = regReq.rd;
    end
    // watchdog
    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
    initial begin
        void'($urandom(34586));
        for (int i = 0; i < 8; i++) inputVals[i] = 10'($urandom % 1024);
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(OFS_STAT_CTRL, RST_STAT_CTRL, "statusReset");
        rd(OFS_CONV_CTRL, RST_CONV_CTRL, "ctrlReset");
        rd(OFS_RES_LOW, 8'h00, "lowReset");
        rd(3'h5, 8'h00, "unmapped");
        wr(OFS_STAT_CTRL, 8'h00);
        wait_idle(lenA);
        chk("offNoStart", 8'h00, 8'(sampleEn));
        wr(OFS_CONV_CTRL, 8'h80);
        for (int i = 0; i < 12; i++)
            conv({3'b000, chList[i]}, chList[i] <= CH_LAST_INPUT ? inputVals[chList[i][2:0]] :
                (chList[i] == CH_UPPER_REF ? 10'h3ff : 10'h000), 8'h80);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_CONV_CTRL, modes[i]);
            conv(8'h00, inputVals[0], modes[i]);
        end
        wr(OFS_CONV_CTRL, 8'h80);
        wr(OFS_STAT_CTRL, 8'h00);
        wait_idle(lenA);
        wr(OFS_CONV_CTRL, 8'h8f);
        wr(OFS_STAT_CTRL, 8'h00);
        wait_idle(lenB);
        chk("prescaleSpan", 8'(N * 30), 8'(lenB - lenA));
        wr(OFS_CONV_CTRL, 8'h80);
        f = fmt(8'h80, inputVals[1]);
        wr(OFS_STAT_CTRL, 8'h41);
        wait_idle(lenA);
        chk("irqRaised", 8'h01, 8'(doneIrq));
        wr(OFS_RES_HIGH, 8'h55);
        rd(OFS_RES_HIGH, f[15:8], "resHighKept");
        @(negedge core_clk);
        chk("irqReadClear", 8'h00, 8'(doneIrq));
        wr(OFS_STAT_CTRL, 8'h41);
        wait_idle(lenA);
        wr(OFS_STAT_CTRL, 8'h01);
        @(negedge core_clk);
        chk("irqWriteClear", 8'h00, 8'(doneIrq));
        wait_idle(lenA);
        chk("irqDisabled", 8'h00, 8'(doneIrq));
        rd(OFS_STAT_CTRL, 8'h81, "pollDone");
        wr(OFS_STAT_CTRL, 8'h02);
        repeat (3) @(posedge core_clk);
        wr(OFS_CONV_CTRL, 8'h80);
        @(negedge core_clk);
        chk("abortIdle", 8'h00, 8'(sampleEn));
        repeat (30) @(negedge core_clk);
        rd(OFS_STAT_CTRL, 8'h02, "abortNoFlag");
        rd(OFS_RES_HIGH, f[15:8], "abortKeep");
        wr(OFS_STAT_CTRL, 8'h02);
        wr(OFS_CONV_CTRL, 8'h00);
        @(negedge core_clk);
        chk("powerOffIdle", 8'h00, {6'h00, samplePowerOn, sampleEn});
        wr(OFS_CONV_CTRL, 8'h80);
        wr(OFS_STAT_CTRL, 8'h20);
        repeat (20) @(negedge core_clk);
        rd(OFS_STAT_CTRL, 8'ha0, "contDone");
        f = fmt(8'h80, inputVals[0]);
        rd(OFS_RES_HIGH, f[15:8], "contHigh");
        repeat (20) @(negedge core_clk);
        rd(OFS_STAT_CTRL, 8'ha0, "contAgain");
        wr(OFS_CONV_CTRL, 8'h80);
        // pending interrupt, then a reset after the conversion has ended must drop it
        wr(OFS_STAT_CTRL, 8'h40);
        wait_idle(lenA);
        chk("irqBeforeReset", 8'h01, 8'(doneIrq));
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        chk("irqReset", 8'h00, 8'(doneIrq));
        repeat (4) @(posedge core_clk);
        wrap_up();
    end
endmodule // adcr_top_tb
`default_nettype wire
